// *** hdl/qdec_pkg.sv ***
/*
  Constants of the quadrature decoder register block: offsets, control
  field positions, reset values and status bit positions.
  Assumes a plain single-cycle register port on a 100 MHz sys_clk.
*/
// Overview of operation
// - Eleven registers answer at byte offsets 0x000 to 0x028, one 32-bit word each.
// - Offset 0x014 reads the velocity period timer and ignores writes.
// - Offset 0x018 reads the predivided edges (velocity ticks) counted so far in the running period.
// - Offset 0x01C reads the predivided edge (velocity tick) total of the last finished period.
// - Offset 0x010 holds the timer reload value, zero after reset.
// - Writing ones to offset 0x028 clears those pending bits; zeros do nothing.
// - Control bit 4 clear resets position at the limit, set resets it on index.
// - Control bit 3 clear counts first-phase edges only, set counts both phases.
// - Control bit 2 set reads the phases as step and direction, clear as quadrature.
// - Control bit 1 set swaps the two phase inputs before decoding.
// - Control bit 0 enables decoding; all control bits reset to zero.
// - Forward past the limit wraps to zero; backward from zero loads the limit.
// - The timer reloads on the clock after zero, so a period is load plus one clocks.
package qdec_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_CTL = 12'h000;
    localparam logic [11:0] OFS_STAT = 12'h004;
    localparam logic [11:0] OFS_POS = 12'h008;
    localparam logic [11:0] OFS_MAX = 12'h00C;
    localparam logic [11:0] OFS_LOAD = 12'h010;
    localparam logic [11:0] OFS_TIME = 12'h014;
    localparam logic [11:0] OFS_COUNT = 12'h018;
    localparam logic [11:0] OFS_SPEED = 12'h01C;
    localparam logic [11:0] OFS_MASK = 12'h020;
    localparam logic [11:0] OFS_RAW = 12'h024;
    localparam logic [11:0] OFS_ISC = 12'h028;
    localparam int unsigned CTL_W = 13;
    localparam int unsigned B_EN = 0;
    localparam int unsigned B_SWAP = 1;
    localparam int unsigned B_SIG = 2;
    localparam int unsigned B_CAP = 3;
    localparam int unsigned B_RES = 4;
    localparam int unsigned B_VEL = 5;
    localparam int unsigned B_DIV = 6;
    localparam int unsigned B_INV_FIRST = 9;
    localparam int unsigned B_INV_SECOND = 10;
    localparam int unsigned B_INV_INDEX = 11;
    localparam int unsigned B_STALL = 12;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_INDEX = 0;
    localparam int unsigned IRQ_TIMER = 1;
    localparam int unsigned IRQ_DIR = 2;
    localparam int unsigned IRQ_ERR = 3;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [CTL_W-1:0] RST_CTL = 13'h0000;
    localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
    localparam logic [6:0] RST_PREDIV = 7'h00;
endpackage

// *** hdl/qdec_edge.sv ***
/*
  Phase conditioning and edge decoding: inversion, swap, quadrature or
  step/direction interpretation, index edge and phase error detection.
  Assumes encoder pins already synchronous to sys_clk.
*/
module qdec_edge (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Encoder pins
    input wire logic first_quadrature_input,
    input wire logic second_quadrature_input,
    input wire logic index_in,
    // Configuration
    input wire logic run,
    input wire logic first_phase_invert,
    input wire logic second_phase_invert,
    input wire logic index_polarity_invert,
    input wire logic phase_swap,
    input wire logic signal_format_select,
    input wire logic edge_count_select,
    // Decoded events
    output logic step,
    output logic reverse,
    output logic index_hit,
    output logic phase_error
);
    logic a, b, ix, prev_a, prev_b, prev_i;
    logic next_step, next_reverse, next_index_hit, next_phase_error;

    always_comb begin
        a = first_quadrature_input ^ first_phase_invert;
        b = second_quadrature_input ^ second_phase_invert;
        ix = index_in ^ index_polarity_invert;
        if (phase_swap) begin
            a = second_quadrature_input ^ second_phase_invert;
            b = first_quadrature_input ^ first_phase_invert;
        end
        next_step = 1'b0;
        next_reverse = reverse;
        next_phase_error = 1'b0;
        next_index_hit = run & ix & ~prev_i;
        if (!run) begin
            next_step = 1'b0;
        end else if (signal_format_select) begin
            next_step = a & ~prev_a;
            if (next_step) begin
                next_reverse = b;
            end
        end else if ((a ^ prev_a) && (b ^ prev_b)) begin
            next_phase_error = 1'b1;
        end else if (a ^ prev_a) begin
            next_step = 1'b1;
            next_reverse = (a == b);
        end else if ((b ^ prev_b) && edge_count_select) begin
            next_step = 1'b1;
            next_reverse = (a != b);
        end
    end

    // Previous levels track even when stopped, so enabling makes no false edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            prev_i <= 1'b0;
            step <= 1'b0;
            reverse <= 1'b0;
            index_hit <= 1'b0;
            phase_error <= 1'b0;
        end else begin
            prev_a <= a;
            prev_b <= b;
            prev_i <= ix;
            step <= next_step;
            reverse <= next_reverse;
            index_hit <= next_index_hit;
            phase_error <= next_phase_error;
        end
    end
endmodule

// *** hdl/qdec_regs.sv ***
/*
  Quadrature decoder register block: register port, position integrator,
  velocity timer, predivider and edge counter, sticky event bits.
  Assumes a master that never issues read and write in the same cycle.
*/
// The plain strobed port was left to the implementer.
module qdec_regs (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [qdec_pkg::ADDR_W-1:0] addr,
    input wire logic [31:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rd_data,
    // Encoder pins and debug halt
    input wire logic first_quadrature_input,
    input wire logic second_quadrature_input,
    input wire logic index_in,
    input wire logic cpu_halted
);
    import qdec_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    logic [CTL_W-1:0] ctl, next_ctl;
    logic [31:0] pos, next_pos, maxpos, next_maxpos, load, next_load;
    logic [31:0] timer, next_timer, count, next_count, speed, next_speed;
    logic [IRQ_W-1:0] mask, next_mask, raw, next_raw, ev;
    logic [6:0] prediv, next_prediv;
    logic [31:0] next_rd_data;
    logic last_rev, next_last_rev, err_stat, next_err_stat;
    logic run, vel_run, step, reverse, index_hit, phase_error, vel_tick;

    // Halt freeze stops both integrator and timer so a debug stop loses no time base
    assign run = ctl[B_EN] & ~(ctl[B_STALL] & cpu_halted);
    // Velocity logic needs the decoder running as well
    assign vel_run = run & ctl[B_VEL];

    qdec_edge qdec_edge_i (
        .sys_clk(sys_clk),
        .rst(rst),
        .first_quadrature_input(first_quadrature_input),
        .second_quadrature_input(second_quadrature_input),
        .index_in(index_in),
        .run(run),
        .first_phase_invert(ctl[B_INV_FIRST]),
        .second_phase_invert(ctl[B_INV_SECOND]),
        .index_polarity_invert(ctl[B_INV_INDEX]),
        .phase_swap(ctl[B_SWAP]),
        .signal_format_select(ctl[B_SIG]),
        .edge_count_select(ctl[B_CAP]),
        .step(step),
        .reverse(reverse),
        .index_hit(index_hit),
        .phase_error(phase_error)
    );

    always_comb begin
        ev = '0;
        ev[IRQ_INDEX] = index_hit;
        ev[IRQ_TIMER] = vel_run && (timer == 32'h0000_0000);
        ev[IRQ_DIR] = step && (reverse != last_rev);
        ev[IRQ_ERR] = phase_error;
        // Predivider: one velocity tick every 2^n decoded edges
        vel_tick = 1'b0;
        next_prediv = prediv;
        if (vel_run && step) begin
            next_prediv = prediv + 7'h01;
            if (prediv == 7'((8'h01 << ctl[B_DIV +: 3]) - 8'h01)) begin
                next_prediv = RST_PREDIV;
                vel_tick = 1'b1;
            end
        end
    end

    always_comb begin
        next_ctl = ctl;
        next_pos = pos;
        next_maxpos = maxpos;
        next_load = load;
        next_timer = timer;
        next_count = count;
        next_speed = speed;
        next_mask = mask;
        next_raw = raw;
        next_last_rev = last_rev;
        next_err_stat = err_stat | phase_error;
        // Position integrator; index wins over a step in the same cycle
        if (step) begin
            next_last_rev = reverse;
        end
        if (run && ctl[B_RES] && index_hit) begin
            next_pos = RST_WORD;
        end else if (step && !reverse) begin
            next_pos = (pos >= maxpos) ? RST_WORD : pos + 32'h0000_0001;
        end else if (step) begin
            next_pos = (pos == RST_WORD) ? maxpos : pos - 32'h0000_0001;
        end
        // Velocity timer and edge counter
        if (vel_run) begin
            if (timer == 32'h0000_0000) begin
                next_timer = load;
                next_speed = count + {31'h0000_0000, vel_tick};
                next_count = RST_WORD;
            end else begin
                next_timer = timer - 32'h0000_0001;
                next_count = count + {31'h0000_0000, vel_tick};
            end
        end
        // Register writes; writes to read-only offsets fall through
        if (wr_en) begin
            if (hit(addr, OFS_CTL)) begin
                next_ctl = wr_data[CTL_W-1:0];
            end
            if (hit(addr, OFS_POS)) begin
                next_pos = wr_data;
            end
            if (hit(addr, OFS_MAX)) begin
                next_maxpos = wr_data;
            end
            if (hit(addr, OFS_LOAD)) begin
                next_load = wr_data;
            end
            if (hit(addr, OFS_MASK)) begin
                next_mask = wr_data[IRQ_W-1:0];
            end
            if (hit(addr, OFS_ISC)) begin
                next_raw = raw & ~wr_data[IRQ_W-1:0];
            end
        end
        // A new event beats a clear in the same cycle
        next_raw = next_raw | ev;
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_rd_data = 32'h0000_0000;
        if (rd_en) begin
            case (addr)
                OFS_CTL: next_rd_data = {19'h0_0000, ctl};
                OFS_STAT: next_rd_data = {30'h0000_0000, last_rev, err_stat};
                OFS_POS: next_rd_data = pos;
                OFS_MAX: next_rd_data = maxpos;
                OFS_LOAD: next_rd_data = load;
                OFS_TIME: next_rd_data = timer;
                OFS_COUNT: next_rd_data = count;
                OFS_SPEED: next_rd_data = speed;
                OFS_MASK: next_rd_data = {28'h000_0000, mask};
                OFS_RAW: next_rd_data = {28'h000_0000, raw};
                OFS_ISC: next_rd_data = {28'h000_0000, raw & mask};
                default: next_rd_data = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl <= RST_CTL;
            pos <= RST_WORD;
            maxpos <= RST_WORD;
            load <= RST_WORD;
            timer <= RST_WORD;
            count <= RST_WORD;
            speed <= RST_WORD;
            mask <= RST_IRQ;
            raw <= RST_IRQ;
            prediv <= RST_PREDIV;
            last_rev <= 1'b0;
            err_stat <= 1'b0;
            rd_data <= RST_WORD;
        end else begin
            ctl <= next_ctl;
            pos <= next_pos;
            maxpos <= next_maxpos;
            load <= next_load;
            timer <= next_timer;
            count <= next_count;
            speed <= next_speed;
            mask <= next_mask;
            raw <= next_raw;
            prediv <= next_prediv;
            last_rev <= next_last_rev;
            err_stat <= next_err_stat;
            rd_data <= next_rd_data;
        end
    end

    property p_ctl_read;
        @(posedge sys_clk) disable iff (rst)
        rd_en && hit(addr, OFS_CTL) |=> rd_data == {19'h0_0000, $past(ctl)};
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control read mismatch");

    property p_time_ro;
        @(posedge sys_clk) disable iff (rst)
        wr_en && hit(addr, OFS_TIME) && !vel_run |=> timer == $past(timer);
    endproperty
    a_time_ro: assert property (p_time_ro) else $error("timer changed by write");

    property p_reload;
        @(posedge sys_clk) disable iff (rst)
        vel_run && timer == 32'h0000_0000 |=> timer == $past(load) && count == 32'h0000_0000;
    endproperty
    a_reload: assert property (p_reload) else $error("timer reload wrong");

    property p_speed;
        @(posedge sys_clk) disable iff (rst)
        vel_run && timer == 32'h0000_0000 && !vel_tick |=> speed == $past(count);
    endproperty
    a_speed: assert property (p_speed) else $error("velocity capture wrong");

    property p_w1c;
        @(posedge sys_clk) disable iff (rst)
        wr_en && hit(addr, OFS_ISC) && ev == 4'h0 |=> raw == ($past(raw) & ~$past(wr_data[IRQ_W-1:0]));
    endproperty
    a_w1c: assert property (p_w1c) else $error("pending clear wrong");

    property p_wrap_fwd;
        @(posedge sys_clk) disable iff (rst)
        step && !reverse && pos == maxpos && !index_hit && !wr_en |=> pos == 32'h0000_0000;
    endproperty
    a_wrap_fwd: assert property (p_wrap_fwd) else $error("forward wrap wrong");

    property p_wrap_back;
        @(posedge sys_clk) disable iff (rst)
        step && reverse && pos == 32'h0000_0000 && !index_hit && !wr_en |=> pos == $past(maxpos);
    endproperty
    a_wrap_back: assert property (p_wrap_back) else $error("backward wrap wrong");

    property p_index;
        @(posedge sys_clk) disable iff (rst)
        run && ctl[B_RES] && index_hit && !wr_en |=> pos == 32'h0000_0000;
    endproperty
    a_index: assert property (p_index) else $error("index reset missed");

    property p_disabled;
        @(posedge sys_clk) disable iff (rst)
        !ctl[B_EN] && !wr_en ##1 !ctl[B_EN] && !wr_en |=> $stable(pos);
    endproperty
    a_disabled: assert property (p_disabled) else $error("position moved while disabled");

    property p_rd_idle;
        @(posedge sys_clk) disable iff (rst)
        !rd_en |=> rd_data == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");

    property p_pos_read;
        @(posedge sys_clk) disable iff (rst)
        rd_en && hit(addr, OFS_POS) |=> rd_data == $past(pos);
    endproperty
    a_pos_read: assert property (p_pos_read) else $error("position read mismatch");

    property p_ctl_write;
        @(posedge sys_clk) disable iff (rst)
        wr_en && hit(addr, OFS_CTL) |=> ctl == $past(wr_data[CTL_W-1:0]);
    endproperty
    a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

    property p_load_write;
        @(posedge sys_clk) disable iff (rst)
        wr_en && hit(addr, OFS_LOAD) |=> load == $past(wr_data);
    endproperty
    a_load_write: assert property (p_load_write) else $error("reload write lost");

    property p_timer_count;
        @(posedge sys_clk) disable iff (rst)
        vel_run && timer != 32'h0000_0000 |=> timer == $past(timer) - 32'h0000_0001;
    endproperty
    a_timer_count: assert property (p_timer_count) else $error("timer did not count down");

    property p_count_tick;
        @(posedge sys_clk) disable iff (rst)
        vel_run && timer != 32'h0000_0000 |=> count == $past(count) + {31'h0000_0000, $past(vel_tick)};
    endproperty
    a_count_tick: assert property (p_count_tick) else $error("edge count wrong");

    property p_vel_hold;
        @(posedge sys_clk) disable iff (rst)
        !vel_run |=> $stable(timer) && $stable(count) && $stable(speed);
    endproperty
    a_vel_hold: assert property (p_vel_hold) else $error("velocity state moved while off");

    property p_step_fwd;
        @(posedge sys_clk) disable iff (rst)
        step && !reverse && pos < maxpos && !index_hit && !wr_en |=> pos == $past(pos) + 32'h0000_0001;
    endproperty
    a_step_fwd: assert property (p_step_fwd) else $error("forward step wrong");

    property p_step_back;
        @(posedge sys_clk) disable iff (rst)
        step && reverse && pos != 32'h0000_0000 && !index_hit && !wr_en |=> pos == $past(pos) - 32'h0000_0001;
    endproperty
    a_step_back: assert property (p_step_back) else $error("backward step wrong");

    property p_index_off;
        @(posedge sys_clk) disable iff (rst)
        index_hit && !ctl[B_RES] && !step && !wr_en |=> $stable(pos);
    endproperty
    a_index_off: assert property (p_index_off) else $error("index moved position in limit mode");

    property p_raw_set;
        @(posedge sys_clk) disable iff (rst)
        ev != 4'h0 |=> (raw & $past(ev)) == $past(ev);
    endproperty
    a_raw_set: assert property (p_raw_set) else $error("event lost against clear");

    property p_stall_timer;
        @(posedge sys_clk) disable iff (rst)
        ctl[B_STALL] && cpu_halted |=> $stable(timer);
    endproperty
    a_stall_timer: assert property (p_stall_timer) else $error("timer ran during halt");
endmodule

// *** test/qdec_enc_model.sv ***
/*
  Behavioural rotary encoder: two quadrature phases and an index pulse,
  with a step/direction form for the decoder's alternate input mode.
  Assumes the bench calls its tasks right after a rising sys_clk edge.
*/
module qdec_enc_model (
    // Clock
    input wire logic sys_clk,
    // Encoder pins
    output logic phase_a,
    output logic phase_b,
    output logic index_p
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] q;

    initial begin
        q = 2'h0;
        phase_a = 1'b0;
        phase_b = 1'b0;
        index_p = 1'b0;
    end

    // Gray sequence, one phase per step, so no step looks like a phase error
    task automatic move(input logic back, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            q = back ? q - 2'h1 : q + 2'h1;
            phase_a <= q[1] ^ q[0];
            phase_b <= q[1];
            repeat (3) @(posedge sys_clk);
        end
    endtask

    // Direction settles two cycles before the step clock rises
    task automatic clk_dir(input logic back);
        @(posedge sys_clk);
        phase_b <= back;
        repeat (2) @(posedge sys_clk);
        phase_a <= 1'b1;
        repeat (2) @(posedge sys_clk);
        phase_a <= 1'b0;
        q = back ? 2'h3 : 2'h0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic pulse_index();
        @(posedge sys_clk);
        index_p <= 1'b1;
        repeat (2) @(posedge sys_clk);
        index_p <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// *** test/qdec_regs_test.sv ***
/*
  Self-checking bench for the decoder register block: register map,
  position counting modes, index reset, sticky bits and velocity timer.
  Assumes qdec_pkg and the encoder model are compiled first.
*/
module qdec_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    import qdec_pkg::*;

    logic sys_clk, rst, wr_en, rd_en, cpu_halted;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wr_data, rd_data, v, w, t0;
    logic first_quadrature_input, second_quadrature_input, index_in;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;

    qdec_regs qdec_regs_i (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .first_quadrature_input(first_quadrature_input),
        .second_quadrature_input(second_quadrature_input), .index_in(index_in), .cpu_halted(cpu_halted));
    qdec_enc_model qdec_enc_model_i (.sys_clk(sys_clk), .phase_a(first_quadrature_input),
        .phase_b(second_quadrature_input), .index_p(index_in));

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    // Whole run needs about 3000 cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("unexpected at %0t: run did not finish", $time);
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Extra idle edge keeps a strobe from being lowered and raised in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [11:0] a);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(negedge sys_clk);
        v = rd_data;
        @(posedge sys_clk);
    endtask

    task automatic chk(input logic [11:0] a, input logic [31:0] e);
        rd(a);
        cmp_count++;
        if (v !== e) begin
            n_fail++;
            $display("unexpected at %0t: offset %h read %h expected %h", $time, a, v, e);
        end
    endtask

    // Position after n signed steps, wrapping between zero and the limit
    function automatic logic [31:0] step_pos(input logic [31:0] p, input logic [31:0] lim, input int n);
        for (int i = 0; i < (n < 0 ? -n : n); i++) begin
            if (n > 0) begin
                p = (p >= lim) ? 32'h0 : p + 32'h1;
            end else begin
                p = (p == 32'h0) ? lim : p - 32'h1;
            end
        end
        return p;
    endfunction

    initial begin
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wr_data = 32'h0;
        cpu_halted = 1'b0;
        void'($urandom(43));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 12; i++) begin
            chk(12'(i * 4), 32'h0);
        end
        // Velocity bit kept off here so the timer stays at zero
        for (int i = 0; i < 6; i++) begin
            w = $urandom();
            wr(OFS_CTL, w & 32'hFFFF_FFDF);
            chk(OFS_CTL, w & 32'h0000_1FDF);
            wr(OFS_CTL, 32'h0);
            w = $urandom();
            wr(OFS_POS, w);
            chk(OFS_POS, w);
            wr(OFS_MAX, ~w);
            chk(OFS_MAX, ~w);
            wr(OFS_LOAD, w);
            chk(OFS_LOAD, w);
            wr(OFS_TIME, w);
            wr(OFS_COUNT, w);
            wr(OFS_SPEED, w);
            wr(12'h030, w);
            chk(OFS_TIME, 32'h0);
            chk(OFS_COUNT, 32'h0);
            chk(OFS_SPEED, 32'h0);
            chk(12'h030, 32'h0);
        end
        wr(OFS_MAX, 32'h5);
        wr(OFS_POS, 32'h3);
        wr(OFS_CTL, 32'h9);
        qdec_enc_model_i.move(1'b0, 4);
        chk(OFS_POS, step_pos(32'h3, 32'h5, 4));
        qdec_enc_model_i.move(1'b1, 3);
        chk(OFS_POS, step_pos(32'h1, 32'h5, -3));
        wr(OFS_CTL, 32'h1);
        qdec_enc_model_i.move(1'b0, 4);
        chk(OFS_POS, step_pos(32'h4, 32'h5, 2));
        wr(OFS_CTL, 32'hB);
        wr(OFS_POS, 32'h2);
        qdec_enc_model_i.move(1'b0, 4);
        chk(OFS_POS, step_pos(32'h2, 32'h5, -4));
        chk(OFS_STAT, 32'h3);
        wr(OFS_CTL, 32'h0);
        qdec_enc_model_i.move(1'b0, 4);
        chk(OFS_POS, 32'h4);
        wr(OFS_CTL, 32'h1009);
        cpu_halted <= 1'b1;
        qdec_enc_model_i.move(1'b0, 4);
        chk(OFS_POS, 32'h4);
        cpu_halted <= 1'b0;
        qdec_enc_model_i.move(1'b0, 2);
        chk(OFS_POS, step_pos(32'h4, 32'h5, 2));
        wr(OFS_CTL, 32'h5);
        wr(OFS_POS, 32'h2);
        qdec_enc_model_i.clk_dir(1'b0);
        qdec_enc_model_i.clk_dir(1'b0);
        qdec_enc_model_i.clk_dir(1'b1);
        chk(OFS_POS, step_pos(32'h2, 32'h5, 1));
        wr(OFS_CTL, 32'h9);
        wr(OFS_MASK, 32'h1);
        wr(OFS_ISC, 32'hF);
        chk(OFS_ISC, 32'h0);
        qdec_enc_model_i.pulse_index();
        chk(OFS_POS, 32'h3);
        chk(OFS_ISC, 32'h1);
        wr(OFS_ISC, 32'h0);
        chk(OFS_ISC, 32'h1);
        wr(OFS_ISC, 32'h1);
        chk(OFS_ISC, 32'h0);
        wr(OFS_CTL, 32'h19);
        qdec_enc_model_i.pulse_index();
        chk(OFS_POS, 32'h0);
        // Inversions set while stopped, so no false edge on enable
        wr(OFS_CTL, 32'h0A18);
        wr(OFS_CTL, 32'h0A19);
        qdec_enc_model_i.move(1'b0, 2);
        chk(OFS_POS, step_pos(32'h0, 32'h5, -2));
        qdec_enc_model_i.pulse_index();
        chk(OFS_POS, 32'h0);
        wr(OFS_CTL, 32'h0);
        wr(OFS_LOAD, 32'h0000_03E7);
        wr(OFS_CTL, 32'h39);
        qdec_enc_model_i.move(1'b0, 6);
        chk(OFS_COUNT, 32'h6);
        repeat (1100) @(posedge sys_clk);
        chk(OFS_SPEED, 32'h6);
        chk(OFS_COUNT, 32'h0);
        wr(OFS_CTL, 32'h79);
        rd(OFS_COUNT);
        w = v;
        qdec_enc_model_i.move(1'b0, 8);
        chk(OFS_COUNT, w + 32'h4);
        wr(OFS_LOAD, 32'h4);
        repeat (1100) @(posedge sys_clk);
        rd(OFS_TIME);
        t0 = v;
        // Reads are two cycles apart; period is load plus one
        for (int i = 0; i < 8; i++) begin
            chk(OFS_TIME, (t0 >= 32'h2) ? t0 - 32'h2 : t0 + 32'h3);
            t0 = v;
        end
        chk(OFS_RAW, 32'h7);
        chk(OFS_STAT, 32'h1);
        test_done();
    end
endmodule
